// ---- sce_core.sv ----
// Purpose: Executes direct and indirect subroutine calls
// Assumes: Memory writes complete in the cycle they are strobed
// Notes:   Working registers are sampled through a flat input bus
// Functional notes
// - Indirect call pushes 24-bit return address PC plus 2 before branching.
// - Indirect call loads PC 15:1 from source register, clears PC 22:16.
// - Bit 0 of the source register is ignored; PC bit 0 stays zero.
// - Indirect targets are limited to the first 32K instructions.
// - Indirect call is one word; low nibble selects one of 16 registers.
// - Direct call uses two words: low literal bits, then upper 7 bits.
// - Extended variant stores frame-active flag in stacked bit 0, then clears it.
`timescale 1ns/10ps
module sce_core
   import sce_pkg::*;
#(
   parameter bit EXTENDED = 1'b1
)(
   input  wire logic                   clk_in,
   input  wire logic                   rstn_in,
   input  wire logic                   ce_in,
   input  wire logic                   insn_valid_in,
   input  wire logic [INSN_W-1:0]      insn_in,
   input  wire logic [NREG*DW-1:0]     work_regs_in,
   input  wire logic                   frame_set_in,
   output logic                        insn_ready_out,
   output logic [PC_W-1:0]             pc_out,
   output logic [DW-1:0]               stack_pointer_out,
   output logic                        stack_we_out,
   output logic [DW-1:0]               stack_addr_out,
   output logic [DW-1:0]               stack_top_word_out,
   output logic                        stack_frame_active_flag_out,
   output logic                        busy_out
);
   sce_state_t       state_reg;
   logic [PC_W-1:0]  pc_reg;
   logic [PC_W-1:0]  ret_reg;
   logic [PC_W-1:0]  target_reg;
   logic [DW-1:0]    stack_pointer_reg;
   logic             stack_frame_active_flag_reg;
   logic             we_reg;
   logic [DW-1:0]    addr_reg;
   logic [DW-1:0]    data_reg;
   logic             is_dir;
   logic             is_ind;
   logic [3:0]       sel;
   logic [15:0]      lit_low;
   logic [DW-1:0]    source_work_reg;

   sce_decode u_dec (
      .insn_in         (insn_in),
      .is_direct_out   (is_dir),
      .is_indirect_out (is_ind),
      .src_sel_out     (sel),
      .lit_low_out     (lit_low)
   );

   assign source_work_reg = work_regs_in[sel*DW +: DW];

   // Handshake: accept words only while idle or awaiting the second word
   assign insn_ready_out = (state_reg == SCE_IDLE) || (state_reg == SCE_WORD2);
   wire take = ce_in && insn_valid_in && insn_ready_out;

   // One adder shape for every program counter step, so the call paths
   // and the plain fetch path cannot drift apart
   function automatic logic [PC_W-1:0] pc_advance(input logic [PC_W-1:0] pc_now,
                                                  input logic [PC_W-1:0] step);
      pc_advance = pc_now + step;
   endfunction

   // Stack pointer moves one data word per push
   function automatic logic [DW-1:0] sp_advance(input logic [DW-1:0] sp_now);
      sp_advance = sp_now + SP_STEP;
   endfunction

   // Low stacked word; bit 0 is free because return addresses are even
   function automatic logic [DW-1:0] push_low_word(input logic [PC_W-1:0] ret,
                                                   input logic            flag);
      push_low_word = {ret[15:1], flag};
   endfunction

   // High stacked word carries the top byte of the return address, zero padded
   function automatic logic [DW-1:0] push_high_word(input logic [PC_W-1:0] ret);
      push_high_word = {8'h00, ret[23:16]};
   endfunction

   // Upper bits forced low keeps the target in the first 32K words
   function automatic logic [PC_W-1:0] indirect_target(input logic [DW-1:0] src);
      indirect_target = {8'h00, src[15:1], 1'b0};
   endfunction

   logic pushing;
   logic frame_bit;
   assign pushing   = (state_reg == SCE_PUSHL) || (state_reg == SCE_PUSHH);
   // Without the extended variant the stacked bit 0 is simply zero
   assign frame_bit = EXTENDED ? stack_frame_active_flag_reg : 1'b0;

   // Call sequencer
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_reg <= SCE_IDLE;
      end else if (ce_in) begin
         unique case (state_reg)
            SCE_IDLE: begin
               if (take && is_ind) begin
                  state_reg <= SCE_PUSHL;
               end else if (take && is_dir) begin
                  state_reg <= SCE_WORD2;
               end
            end
            SCE_WORD2: begin
               if (take) begin
                  state_reg <= SCE_PUSHL;
               end
            end
            SCE_PUSHL: state_reg <= SCE_PUSHH;
            SCE_PUSHH: state_reg <= SCE_DONE;
            // Spare cycle lets the loaded target settle before the next fetch
            SCE_DONE:  state_reg <= SCE_IDLE;
            default:   state_reg <= SCE_IDLE;
         endcase
      end
   end

   // Return address captured when the call word is taken
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ret_reg <= PC_RESET;
      end else if (take && state_reg == SCE_IDLE) begin
         if (is_ind) begin
            ret_reg <= pc_advance(pc_reg, PC_STEP_IND);
         end else if (is_dir) begin
            ret_reg <= pc_advance(pc_reg, PC_STEP_DIR);
         end
      end
   end

   // Call target: low part with the first word, upper literal with the second
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         target_reg <= PC_RESET;
      end else if (take) begin
         if (state_reg == SCE_IDLE && is_ind) begin
            target_reg <= indirect_target(source_work_reg);
         end else if (state_reg == SCE_IDLE && is_dir) begin
            target_reg <= {8'h00, lit_low};
         end else if (state_reg == SCE_WORD2) begin
            target_reg[22:16] <= insn_in[LIT_HI_W-1:0];
         end
      end
   end

   // Write strobe: one cycle per stacked word
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         we_reg <= 1'b0;
      end else if (ce_in) begin
         we_reg <= pushing;
      end
   end

   // Address follows the pointer, so the high word lands one word above the low
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         addr_reg <= 16'h0000;
      end else if (ce_in && pushing) begin
         addr_reg <= stack_pointer_reg;
      end
   end

   // Write data: low word first, then high word
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         data_reg <= 16'h0000;
      end else if (ce_in) begin
         if (state_reg == SCE_PUSHL) begin
            data_reg <= push_low_word(ret_reg, frame_bit);
         end else if (state_reg == SCE_PUSHH) begin
            data_reg <= push_high_word(ret_reg);
         end
      end
   end

   // Stack pointer: up by one word as each write is strobed, two words per call
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         stack_pointer_reg <= SP_RESET;
      end else if (ce_in && pushing) begin
         stack_pointer_reg <= sp_advance(stack_pointer_reg);
      end
   end

   // Frame flag: cleared once stacked; a same-cycle set from outside wins
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         stack_frame_active_flag_reg <= 1'b0;
      end else if (ce_in) begin
         if (frame_set_in) begin
            stack_frame_active_flag_reg <= 1'b1;
         end else if (EXTENDED && state_reg == SCE_PUSHL) begin
            stack_frame_active_flag_reg <= 1'b0;
         end
      end
   end

   // Program counter: non-call words advance by 2, calls load target after stacking
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pc_reg <= PC_RESET;
      end else if (ce_in) begin
         if (state_reg == SCE_PUSHH) begin
            pc_reg <= target_reg;
         end else if (state_reg == SCE_IDLE && take && !is_ind && !is_dir) begin
            pc_reg <= pc_advance(pc_reg, PC_STEP_IND);
         end
      end
   end

   assign pc_out                      = pc_reg;
   assign stack_pointer_out           = stack_pointer_reg;
   assign stack_we_out                = we_reg;
   assign stack_addr_out              = addr_reg;
   assign stack_top_word_out          = data_reg;
   assign stack_frame_active_flag_out = stack_frame_active_flag_reg;
   assign busy_out                    = !insn_ready_out;
endmodule

// ---- sce_core_asserts.sv ----
// Purpose: Port checks for the call block
// Assumes: ce_in high and no frame set during a call
// Notes:   Bound onto every sce_core
`timescale 1ns/10ps
module sce_core_chk
   import sce_pkg::*;
(
   input  wire logic                clk_in,
   input  wire logic                rstn_in,
   input  wire logic                ce_in,
   input  wire logic                insn_valid_in,
   input  wire logic [INSN_W-1:0]   insn_in,
   input  wire logic [NREG*DW-1:0]  work_regs_in,
   input  wire logic                insn_ready_out,
   input  wire logic [PC_W-1:0]     pc_out,
   input  wire logic [DW-1:0]       stack_pointer_out,
   input  wire logic                stack_we_out,
   input  wire logic [DW-1:0]       stack_addr_out,
   input  wire logic                stack_frame_active_flag_out
);
   logic          ind;
   logic [DW-1:0] src;
   assign ind = ce_in && insn_valid_in && insn_ready_out && insn_in[23:4] == OPC_INDIRECT;
   assign src = work_regs_in[insn_in[3:0]*DW +: DW];
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   chk_ind_push: assert property (ind |-> ##2 stack_we_out ##1 stack_we_out ##1 !stack_we_out)
      else $error("indirect call push strobes wrong");
   chk_ind_busy: assert property (ind |=> !insn_ready_out [*2])
      else $error("indirect call accepted more words");
   chk_ind_target: assert property (ind |-> ##4 pc_out[15:1] == $past(src[15:1], 4))
      else $error("indirect target low bits wrong");
   chk_pc_upper: assert property (ind |-> ##4 pc_out[22:16] == 7'h00 && !pc_out[0])
      else $error("indirect target upper bits not cleared");
   chk_flag_clear: assert property (ind |-> ##4 !stack_frame_active_flag_out)
      else $error("frame flag not cleared");
   chk_sp_addr: assert property (stack_we_out |-> stack_pointer_out == stack_addr_out + SP_STEP)
      else $error("stack pointer not one step past write");
   chk_push_seq: assert property ($rose(stack_we_out) |=> stack_addr_out == $past(stack_addr_out) + SP_STEP)
      else $error("high word not at next stack word");
   chk_sp_moves: assert property ($changed(stack_pointer_out) |-> stack_we_out)
      else $error("stack pointer moved without a write");
endmodule
bind sce_core sce_core_chk u_chk (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
   .insn_valid_in(insn_valid_in), .insn_in(insn_in), .work_regs_in(work_regs_in),
   .insn_ready_out(insn_ready_out), .pc_out(pc_out), .stack_pointer_out(stack_pointer_out),
   .stack_we_out(stack_we_out), .stack_addr_out(stack_addr_out),
   .stack_frame_active_flag_out(stack_frame_active_flag_out));

// ---- sce_core_bench.sv ----
// Purpose: Directed bench for the call block
// Assumes: Clock enable dropped only while the block is idle
// Notes:   Stack contents read back through the memory model
`timescale 1ns/10ps
module sce_core_bench import sce_pkg::*; ;
   logic               clk, rstn, ce, valid, fset, rdy, we, flag, busy;
   logic [INSN_W-1:0]  insn;
   logic [NREG*DW-1:0] regs;
   logic [PC_W-1:0]    pc;
   logic [DW-1:0]      sp, addr, data;
   int                 n_errors, cmp_count;
   sce_core u_dut (.clk_in(clk), .rstn_in(rstn), .ce_in(ce), .insn_valid_in(valid),
      .insn_in(insn), .work_regs_in(regs), .frame_set_in(fset), .insn_ready_out(rdy),
      .pc_out(pc), .stack_pointer_out(sp), .stack_we_out(we), .stack_addr_out(addr),
      .stack_top_word_out(data), .stack_frame_active_flag_out(flag), .busy_out(busy));
   sce_stack_mem u_mem (.clk_in(clk), .we_in(we), .addr_in(addr), .data_in(data));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      while (rdy !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      if (rdy !== 1'b1) begin
         n_errors++;
         $display("ERROR ready expected 1 seen %b", rdy);
      end
   endtask
   // Valid stays up between words so two words can go back to back
   task automatic issue(input logic [23:0] w);
      @(negedge clk);
      insn = w;
      valid = 1'b1;
      wait_rdy();
      @(posedge clk);
   endtask
   task automatic idle;
      @(negedge clk);
      valid = 1'b0;
      wait_rdy();
   endtask
   task automatic finish_test;
      $display("compares %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic t_direct;
      issue(24'h022800);
      issue(24'h000007);
      idle();
      chk("pc", 24'h072800, pc);
      chk("sp", 24'h000804, sp);
      chk("low", 24'h000004, u_mem.rd(16'h0800));
      chk("high", 24'h000000, u_mem.rd(16'h0802));
      $display("test direct done");
   endtask
   // Flag set first so the stacked bit 0 shows it; source bit 0 set to be ignored
   task automatic t_indirect;
      @(negedge clk);
      fset = 1'b1;
      @(negedge clk);
      fset = 1'b0;
      issue(24'h010005);
      @(negedge clk);
      valid = 1'b0;
      chk("busy", 24'h000001, busy);
      idle();
      chk("pc", 24'h005500, pc);
      chk("low", 24'h002803, u_mem.rd(16'h0804));
      chk("high", 24'h000007, u_mem.rd(16'h0806));
      chk("flag", 24'h000000, flag);
      chk("sp", 24'h000808, sp);
      $display("test indirect done");
   endtask
   // Enable low must hold back both a fetch and a flag set
   task automatic t_freeze;
      @(negedge clk);
      ce = 1'b0;
      fset = 1'b1;
      insn = 24'h123456;
      valid = 1'b1;
      repeat (3) @(negedge clk);
      chk("pc", 24'h005500, pc);
      chk("flag", 24'h000000, flag);
      chk("sp", 24'h000808, sp);
      fset = 1'b0;
      ce = 1'b1;
      @(negedge clk);
      valid = 1'b0;
      chk("pc", 24'h005502, pc);
      chk("busy", 24'h000000, busy);
      $display("test freeze done");
   endtask
   // Mid-run reset clears the flag; a call follows straight after release
   task automatic t_reset;
      @(negedge clk);
      fset = 1'b1;
      @(negedge clk);
      fset = 1'b0;
      rstn = 1'b0;
      @(negedge clk);
      rstn = 1'b1;
      chk("pc", PC_RESET, pc);
      chk("sp", SP_RESET, sp);
      chk("flag", 24'h000000, flag);
      chk("busy", 24'h000000, busy);
      issue(24'h010005);
      idle();
      chk("pc", 24'h005500, pc);
      chk("low", 24'h000002, u_mem.rd(16'h0800));
      chk("high", 24'h000000, u_mem.rd(16'h0802));
      chk("sp", 24'h000804, sp);
      $display("test reset done");
   endtask
   initial begin
      {rstn, valid, fset} = 3'b000;
      ce = 1'b1;
      insn = 24'h000000;
      regs = {NREG*DW{1'b1}};
      regs[5*DW +: DW] = 16'h5501;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      chk("pc", PC_RESET, pc);
      chk("sp", SP_RESET, sp);
      chk("flag", 24'h000000, flag);
      t_direct();
      t_indirect();
      t_freeze();
      t_reset();
      finish_test();
   end
   initial begin
      #20000;
      n_errors++;
      $display("ERROR watchdog expected done seen timeout");
      finish_test();
   end
endmodule

// ---- sce_decode.sv ----
// Purpose: Classifies a fetched instruction word as a call form
// Assumes: Word is stable while valid is high
// Notes:   Purely combinational
`timescale 1ns/10ps
module sce_decode
   import sce_pkg::*;
(
   input  wire logic [INSN_W-1:0]    insn_in,
   output logic                      is_direct_out,
   output logic                      is_indirect_out,
   output logic [REG_SEL_W-1:0]      src_sel_out,
   output logic [15:0]               lit_low_out
);
   always_comb begin
      is_direct_out   = (insn_in[23:16] == OPC_DIRECT) && !insn_in[0];
      is_indirect_out = (insn_in[23:4] == OPC_INDIRECT);
      src_sel_out     = insn_in[3:0];
      lit_low_out     = {insn_in[15:1], 1'b0};
   end
endmodule

// ---- sce_pkg.sv ----
// Purpose: Shared constants for the subroutine call execution block
// Assumes: 24-bit program counter, 16-bit data words, word-addressed stack pointer in bytes
// Notes:   Opcode patterns match the upper bits of a 24-bit instruction word
package sce_pkg;
   localparam int          PC_W          = 24;
   localparam int          DW            = 16;
   localparam int          INSN_W        = 24;
   localparam int          NREG          = 16;
   localparam int          REG_SEL_W     = 4;
   localparam int          LIT_HI_W      = 7;
   localparam logic [7:0]  OPC_DIRECT    = 8'h02;
   localparam logic [19:0] OPC_INDIRECT  = 20'h01000;
   localparam logic [16:0] OPC_DIR_WORD2 = 17'h00000;
   localparam logic [23:0] PC_STEP_IND   = 24'h000002;
   localparam logic [23:0] PC_STEP_DIR   = 24'h000004;
   localparam logic [15:0] SP_STEP       = 16'h0002;
   localparam logic [23:0] PC_RESET      = 24'h000000;
   localparam logic [15:0] SP_RESET      = 16'h0800;
   typedef enum logic [4:0] {
      SCE_IDLE  = 5'b00001,
      SCE_WORD2 = 5'b00010,
      SCE_PUSHL = 5'b00100,
      SCE_PUSHH = 5'b01000,
      SCE_DONE  = 5'b10000
   } sce_state_t;
endpackage

// ---- sce_stack_mem.sv ----
// Purpose: Data stack memory model beside the call block
// Assumes: Writes land at the strobing edge
// Notes:   Unwritten words read all ones, never the last value
`timescale 1ns/10ps
module sce_stack_mem (
   input  wire logic        clk_in,
   input  wire logic        we_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [15:0] data_in
);
   logic [15:0] mem [0:65535];
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 16'hFFFF;
      end
   end
   always @(posedge clk_in) begin
      if (we_in) begin
         mem[addr_in] <= data_in;
      end
   end
   function automatic logic [15:0] rd(input logic [15:0] a);
      return mem[a];
   endfunction
endmodule
